// ===== logic/conv_ctrl_pkg.sv
/*
 * Shared constants and types for the converter mode and fault control block.
 * Assumes one 100 MHz controller clock and a 32-bit AXI4-Lite register bus.
 */
package conv_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFFSET   = 8'h00;
  localparam logic [7:0] INT_STAT_OFFSET = 8'h04;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h08;
  localparam logic [7:0] THRESH_OFFSET   = 8'h0c;

  // Status register fields
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_FAULT_BIT  = 2;
  localparam int unsigned ST_SWITCH_BIT = 3;
  localparam int unsigned ST_BLANK_BIT  = 4;
  localparam int unsigned ST_OVPOFF_BIT = 5;
  localparam int unsigned ST_SKIP_BIT   = 6;

  // Interrupt status and mask fields
  localparam int unsigned EV_W          = 3;
  localparam int unsigned EV_FAULT_BIT  = 0;
  localparam int unsigned EV_MODE_BIT   = 1;
  localparam int unsigned EV_BLANK_BIT  = 2;
  localparam logic [2:0]  INT_MASK_RESET = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Undervoltage blanking in slew-rate clock periods
  localparam int unsigned BLANK_SLEW_CYCLES = 256;
  localparam int unsigned BLANK_CNT_W       = 9;

  // Current-limit threshold
  localparam int unsigned SET_MV_W       = 12;
  localparam int unsigned THRESH_MV_W    = 9;
  localparam logic [8:0]  CURRENT_LIMIT_SETTING_DEFAULT_MV = 9'h064;
  localparam logic [11:0] CURRENT_LIMIT_SETTING_DIVISOR    = 12'h00a;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN,
    MODE_NO_FAULT,
    MODE_FORCED_PWM,
    MODE_AUTO
  } mode_type;

  // Decoded levels of the mode/shutdown pin, one-hot from the level detector
  typedef struct packed {
    logic gnd;
    logic test;
    logic open;
    logic supply;
  } mode_pin_type;

  typedef struct packed {
    logic over;
    logic under;
    logic thermal;
  } trips_type;

endpackage

// ===== logic/conv_mode_fault.sv
/*
 * Mode decode, fault latch, gate-drive override, current-limit threshold,
 * interrupt logic and AXI4-Lite register slave of a step-down controller.
 * Assumes pin-level and comparator inputs are asynchronous, and the modulator
 * request and limit setting come from logic on aclk.
 */
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
// Behaviour
// - Ground level: shutdown, low-side drive forced high
// - Test level: protections off, fault latch cleared
// - Test mode modulates like automatic run mode
// - Open level: forced PWM, never pulse-skip
// - Forced PWM keeps low side on, current reverses
// - Supply level: automatic PWM and pulse-skip switchover
// - Skip starts when inductor current reaches zero
// - Trips latch fault; stop switching, drive high
// - Fault clears only by power or ground; the latch also clears at test level
// - Limit default 100mV, else setting divided by ten
// - Undervoltage ignored for first 256 slew cycles
// - Overvoltage-disable input high suppresses overvoltage protection
`timescale 1ns/100ps
module conv_mode_fault (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [conv_ctrl_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [conv_ctrl_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [conv_ctrl_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [conv_ctrl_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  input  wire conv_ctrl_pkg::mode_pin_type       mode_shutdown_pin,
  input  wire conv_ctrl_pkg::trips_type          trips,
  input  wire logic                              ovp_disable_pin,
  input  wire logic                              zero_cross,
  input  wire logic                              slew_clock,
  input  wire logic                              low_side_request,
  input  wire logic                              current_limit_setting_at_supply,
  input  wire logic [conv_ctrl_pkg::SET_MV_W-1:0] current_limit_setting,
  output logic                                   low_side_gate_drive,
  output logic                                   switching_enable,
  output logic                                   skip_active,
  output logic                                   reverse_current_allowed,
  output conv_ctrl_pkg::mode_type                mode,
  output logic                                   fault_latched,
  output logic [conv_ctrl_pkg::THRESH_MV_W-1:0]  valley_threshold_mv,
  output logic                                   irq
);

  logic [9:0]                          meta_q;
  logic [9:0]                          sync_q;
  conv_ctrl_pkg::mode_pin_type         pin_s;
  conv_ctrl_pkg::trips_type            trip_s;
  logic                                ovp_off_s;
  logic                                zc_s;
  logic                                slew_s;
  logic                                slew_prev_q;
  conv_ctrl_pkg::mode_type             mode_q;
  conv_ctrl_pkg::mode_type             mode_d;
  logic                                fault_q;
  logic                                fault_set;
  logic                                run_mode;
  logic                                auto_like;
  logic [conv_ctrl_pkg::BLANK_CNT_W-1:0] blank_cnt_q;
  logic                                blanking;
  logic                                blank_prev_q;
  logic                                drive_q;
  logic                                skip_q;
  logic [conv_ctrl_pkg::THRESH_MV_W-1:0] thresh_q;
  logic [conv_ctrl_pkg::SET_MV_W-1:0]  set_div;
  logic [conv_ctrl_pkg::EV_W-1:0]      events;
  logic [conv_ctrl_pkg::EV_W-1:0]      int_stat_q;
  logic [conv_ctrl_pkg::EV_W-1:0]      int_mask_q;
  logic                                aw_got_q;
  logic                                w_got_q;
  logic [conv_ctrl_pkg::ADDR_W-1:0]    aw_addr_q;
  logic [conv_ctrl_pkg::DATA_W-1:0]    w_data_q;
  logic [3:0]                          w_strb_q;
  logic                                bvalid_q;
  logic [1:0]                          bresp_q;
  logic                                rvalid_q;
  logic [conv_ctrl_pkg::DATA_W-1:0]    rdata_q;
  logic [1:0]                          rresp_q;
  logic                                wr_do;
  logic                                rd_do;
  logic                                stat_rd_clear;

  // Two-stage synchroniser for every asynchronous input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 10'h200; // Pins read as ground until sampled
      sync_q <= 10'h200;
    end else begin
      meta_q <= {mode_shutdown_pin, trips, ovp_disable_pin, zero_cross, slew_clock};
      sync_q <= meta_q;
    end
  end

  assign pin_s     = sync_q[9:6];
  assign trip_s    = sync_q[5:3];
  assign ovp_off_s = sync_q[2];
  assign zc_s      = sync_q[1];
  assign slew_s    = sync_q[0];

  // Mode resolution each clock
  always_comb begin
    if (pin_s.gnd) begin
      mode_d = conv_ctrl_pkg::MODE_SHUTDOWN;
    end else if (pin_s.test) begin
      mode_d = conv_ctrl_pkg::MODE_NO_FAULT;
    end else if (pin_s.supply) begin
      mode_d = conv_ctrl_pkg::MODE_AUTO;
    end else begin
      mode_d = conv_ctrl_pkg::MODE_FORCED_PWM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= conv_ctrl_pkg::MODE_SHUTDOWN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign run_mode  = (mode_q == conv_ctrl_pkg::MODE_FORCED_PWM) || (mode_q == conv_ctrl_pkg::MODE_AUTO);
  assign auto_like = (mode_q == conv_ctrl_pkg::MODE_AUTO) || (mode_q == conv_ctrl_pkg::MODE_NO_FAULT);

  // Undervoltage blanking, restarted while shut down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slew_prev_q <= 1'b0;
      blank_cnt_q <= '0;
    end else begin
      slew_prev_q <= slew_s;
      if (mode_q == conv_ctrl_pkg::MODE_SHUTDOWN) begin
        blank_cnt_q <= '0;
      end else if (blanking && slew_s && !slew_prev_q) begin
        blank_cnt_q <= blank_cnt_q + 1'b1;
      end
    end
  end

  assign blanking = blank_cnt_q < conv_ctrl_pkg::BLANK_CNT_W'(conv_ctrl_pkg::BLANK_SLEW_CYCLES);

  // Fault latch: trips only act in the run modes
  assign fault_set = run_mode && ((trip_s.over && !ovp_off_s)
                                  || (trip_s.under && !blanking)
                                  || trip_s.thermal);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (!run_mode) begin
      fault_q <= 1'b0;
    end
  end

  // Gate drive and modulator steering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_q <= 1'b1;
      skip_q  <= 1'b0;
    end else begin
      skip_q <= auto_like && !fault_q && zc_s;
      if (mode_q == conv_ctrl_pkg::MODE_SHUTDOWN || fault_q) begin
        drive_q <= 1'b1;
      end else if (auto_like && zc_s) begin
        drive_q <= 1'b0;
      end else begin
        drive_q <= low_side_request;
      end
    end
  end

  // Valley current-limit threshold
  assign set_div = current_limit_setting / conv_ctrl_pkg::CURRENT_LIMIT_SETTING_DIVISOR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh_q <= conv_ctrl_pkg::CURRENT_LIMIT_SETTING_DEFAULT_MV;
    end else if (current_limit_setting_at_supply) begin
      thresh_q <= conv_ctrl_pkg::CURRENT_LIMIT_SETTING_DEFAULT_MV;
    end else begin
      thresh_q <= set_div[conv_ctrl_pkg::THRESH_MV_W-1:0];
    end
  end

  assign low_side_gate_drive     = drive_q;
  assign skip_active             = skip_q;
  assign switching_enable        = (mode_q != conv_ctrl_pkg::MODE_SHUTDOWN) && !fault_q;
  assign reverse_current_allowed = (mode_q == conv_ctrl_pkg::MODE_FORCED_PWM) && !fault_q;
  assign mode                    = mode_q;
  assign fault_latched           = fault_q;
  assign valley_threshold_mv     = thresh_q;

  // Interrupt events; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_prev_q <= 1'b1;
    end else begin
      blank_prev_q <= blanking;
    end
  end

  assign events[conv_ctrl_pkg::EV_FAULT_BIT] = fault_set && !fault_q;
  assign events[conv_ctrl_pkg::EV_MODE_BIT]  = mode_d != mode_q;
  assign events[conv_ctrl_pkg::EV_BLANK_BIT] = blank_prev_q && !blanking;

  assign stat_rd_clear = rd_do && (araddr == conv_ctrl_pkg::INT_STAT_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_q <= '0;
    end else if (stat_rd_clear) begin
      int_stat_q <= events;
    end else begin
      int_stat_q <= int_stat_q | events;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // AXI4-Lite write channel
  assign awready = !aw_got_q && !bvalid_q;
  assign wready  = !w_got_q && !bvalid_q;
  assign wr_do   = aw_got_q && w_got_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= conv_ctrl_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        case (aw_addr_q)
          conv_ctrl_pkg::STATUS_OFFSET,
          conv_ctrl_pkg::INT_STAT_OFFSET,
          conv_ctrl_pkg::INT_MASK_OFFSET,
          conv_ctrl_pkg::THRESH_OFFSET: bresp_q <= conv_ctrl_pkg::RESP_OKAY;
          default:                      bresp_q <= conv_ctrl_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask_q <= conv_ctrl_pkg::INT_MASK_RESET;
    end else if (wr_do && aw_addr_q == conv_ctrl_pkg::INT_MASK_OFFSET && w_strb_q[0]) begin
      int_mask_q <= w_data_q[conv_ctrl_pkg::EV_W-1:0];
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // AXI4-Lite read channel
  assign arready = !rvalid_q;
  assign rd_do   = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= conv_ctrl_pkg::RESP_OKAY;
    end else if (rd_do) begin
      rvalid_q <= 1'b1;
      rdata_q  <= '0;
      rresp_q  <= conv_ctrl_pkg::RESP_OKAY;
      case (araddr)
        conv_ctrl_pkg::STATUS_OFFSET: begin
          rdata_q[conv_ctrl_pkg::ST_MODE_LSB +: 2]    <= mode_q;
          rdata_q[conv_ctrl_pkg::ST_FAULT_BIT]        <= fault_q;
          rdata_q[conv_ctrl_pkg::ST_SWITCH_BIT]       <= switching_enable;
          rdata_q[conv_ctrl_pkg::ST_BLANK_BIT]        <= blanking;
          rdata_q[conv_ctrl_pkg::ST_OVPOFF_BIT]       <= ovp_off_s;
          rdata_q[conv_ctrl_pkg::ST_SKIP_BIT]         <= skip_q;
        end
        conv_ctrl_pkg::INT_STAT_OFFSET: rdata_q[conv_ctrl_pkg::EV_W-1:0] <= int_stat_q;
        conv_ctrl_pkg::INT_MASK_OFFSET: rdata_q[conv_ctrl_pkg::EV_W-1:0] <= int_mask_q;
        conv_ctrl_pkg::THRESH_OFFSET:   rdata_q[conv_ctrl_pkg::THRESH_MV_W-1:0] <= thresh_q;
        default:                        rresp_q <= conv_ctrl_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // Checks
  a_shutdown_drive_high: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q == conv_ctrl_pkg::MODE_SHUTDOWN |-> !switching_enable ##1 low_side_gate_drive)
    else $error("drive not high in shutdown");
  a_test_clears_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q == conv_ctrl_pkg::MODE_NO_FAULT |=> !fault_q)
    else $error("fault latch kept in test mode");
  a_test_skips_auto: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == conv_ctrl_pkg::MODE_NO_FAULT && !fault_q && zc_s) |=> skip_q && !drive_q)
    else $error("test mode did not skip like auto");
  a_pwm_never_skips: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q == conv_ctrl_pkg::MODE_FORCED_PWM |=> !skip_q)
    else $error("skip in forced pwm");
  a_pwm_low_side_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == conv_ctrl_pkg::MODE_FORCED_PWM && !fault_q && low_side_request) |=> drive_q)
    else $error("low side cut in forced pwm");
  a_auto_skip_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == conv_ctrl_pkg::MODE_AUTO && !fault_q && zc_s) |=> skip_q)
    else $error("auto mode did not skip at zero");
  a_skip_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    skip_q |-> $past(zc_s) && !$past(fault_q))
    else $error("skip without zero crossing");
  a_trip_latches: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_mode && trip_s.thermal) |=> fault_q ##1 drive_q)
    else $error("thermal trip not latched");
  a_fault_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (fault_q && run_mode && mode_d != conv_ctrl_pkg::MODE_SHUTDOWN && mode_d != conv_ctrl_pkg::MODE_NO_FAULT)
    |=> fault_q [*2])
    else $error("fault cleared by run level");
  a_current_limit_setting_default: assert property (@(posedge aclk) disable iff (!aresetn)
    current_limit_setting_at_supply |=> thresh_q == conv_ctrl_pkg::CURRENT_LIMIT_SETTING_DEFAULT_MV)
    else $error("default limit wrong");
  a_uv_blanked: assert property (@(posedge aclk) disable iff (!aresetn)
    (blanking && !fault_q && !trip_s.over && !trip_s.thermal) |=> !fault_q)
    else $error("undervoltage not blanked");
  a_ovp_suppress: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovp_off_s && !fault_q && !trip_s.under && !trip_s.thermal) |=> !fault_q)
    else $error("overvoltage not suppressed");
  a_mode_priority: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_s.test && !pin_s.gnd) |=> mode_q == conv_ctrl_pkg::MODE_NO_FAULT)
    else $error("mode priority wrong");

endmodule

// ===== tb/power_stage_model.sv
/*
 * Behavioural far side: power stage, trip comparators, slew-rate clock.
 * Assumes the bench sets load, trip and overvoltage-disable levels.
 */
`timescale 1ns/100ps
module power_stage_model (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     light_load,
  input  wire conv_ctrl_pkg::trips_type trip_cmd,
  input  wire logic                     ovp_hold,
  output conv_ctrl_pkg::trips_type      trips,
  output logic                          zero_cross,
  output logic                          slew_clock,
  output logic                          ovp_disable_pin
);
  logic [2:0] div_q;

  // Slew clock at one eighth of aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign slew_clock      = div_q[2];
  assign zero_cross      = light_load;
  assign trips           = trip_cmd;
  assign ovp_disable_pin = ovp_hold;
endmodule

// ===== tb/conv_mode_fault_test.sv
/*
 * Self-checking bench for the mode and fault control block.
 * Assumes power_stage_model as far side and AXI4-Lite tasks as host.
 */
`timescale 1ns/100ps
module conv_mode_fault_test;
  logic                        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                        arvalid, arready, rvalid, rready, ovp_disable_pin, zero_cross;
  logic                        slew_clock, low_side_request, current_limit_setting_at_supply, low_side_gate_drive;
  logic                        switching_enable, skip_active, reverse_current_allowed;
  logic                        fault_latched, irq, light, ovp_hold;
  logic [7:0]                  awaddr, araddr;
  logic [31:0]                 wdata, rdata, rd;
  logic [3:0]                  wstrb;
  logic [1:0]                  bresp, rresp, rs;
  logic [11:0]                 current_limit_setting;
  logic [8:0]                  valley_threshold_mv;
  conv_ctrl_pkg::mode_pin_type mode_shutdown_pin;
  conv_ctrl_pkg::trips_type    trips, trip_cmd;
  conv_ctrl_pkg::mode_type     mode;
  int                          error_cnt, n_tests;
  logic [3:0]                  pv [6] = '{4'hf, 4'h7, 4'h3, 4'h2, 4'h1, 4'h0};
  logic [1:0]                  mv [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h2};
  logic [11:0]                 sv [3] = '{12'h1f4, 12'hbb8, 12'h4d2};

  conv_mode_fault conv_mode_fault_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .mode_shutdown_pin, .trips, .ovp_disable_pin, .zero_cross, .slew_clock, .low_side_request,
    .current_limit_setting_at_supply, .current_limit_setting, .low_side_gate_drive, .switching_enable, .skip_active,
    .reverse_current_allowed, .mode, .fault_latched, .valley_threshold_mv, .irq);
  power_stage_model power_stage_model_i (.aclk, .aresetn, .light_load(light), .trip_cmd, .ovp_hold,
    .trips, .zero_cross, .slew_clock, .ovp_disable_pin);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic pin(input logic [3:0] p);
    mode_shutdown_pin <= conv_ctrl_pkg::mode_pin_type'(p);
    ticks(6);
  endtask
  task automatic cm(input logic [1:0] m);
    check("mode", 32'(m), 32'(mode));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", 32'(re), 32'(bresp));
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] re);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    check("rdata", e, rd & m);
    check("rresp", 32'(re), 32'(rs));
    @(posedge aclk);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    ticks(20000);
    error_cnt++;
    $display("unexpected watchdog: expected done, seen timeout");
    summarize();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {low_side_request, light, ovp_hold, trip_cmd, current_limit_setting} = '0;
    wstrb = 4'hf;
    current_limit_setting_at_supply = 1'b1;
    mode_shutdown_pin = conv_ctrl_pkg::mode_pin_type'(4'h8);
    ticks(5);
    aresetn <= 1'b1;
    ticks(2);
    cm(2'h0);
    check("drive", 1, low_side_gate_drive);
    check("threshold", 32'h64, valley_threshold_mv);
    check("irq", 0, irq);
    for (int i = 0; i < 6; i++) begin
      pin(pv[i]);
      cm(mv[i]);
    end
    current_limit_setting_at_supply <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      current_limit_setting <= sv[i];
      ticks(3);
      check("threshold", 32'(sv[i] / 12'h00a), 32'(valley_threshold_mv));
    end
    rdc(conv_ctrl_pkg::THRESH_OFFSET, 32'h1ff, 32'h7b, conv_ctrl_pkg::RESP_OKAY);
    current_limit_setting_at_supply <= 1'b1;
    pin(4'h2);
    check("threshold", 32'h64, valley_threshold_mv);
    light <= 1'b1;
    low_side_request <= 1'b1;
    ticks(6);
    check("drive", 1, low_side_gate_drive);
    check("skip", 0, skip_active);
    check("reverse", 1, reverse_current_allowed);
    low_side_request <= 1'b0;
    ticks(3);
    check("drive", 0, low_side_gate_drive);
    pin(4'h1);
    light <= 1'b0;
    low_side_request <= 1'b1;
    ticks(6);
    check("drive", 1, low_side_gate_drive);
    check("switching", 1, switching_enable);
    light <= 1'b1;
    ticks(6);
    check("skip", 1, skip_active);
    check("drive", 0, low_side_gate_drive);
    check("reverse", 0, reverse_current_allowed);
    trip_cmd.under <= 1'b1;
    ticks(10);
    check("fault", 0, fault_latched);
    trip_cmd.under <= 1'b0;
    ticks(2300);
    ovp_hold <= 1'b1;
    trip_cmd.over <= 1'b1;
    ticks(10);
    check("fault", 0, fault_latched);
    trip_cmd.over <= 1'b0;
    ovp_hold <= 1'b0;
    rdc(conv_ctrl_pkg::INT_STAT_OFFSET, 32'h7, 32'h6, conv_ctrl_pkg::RESP_OKAY);
    wr(conv_ctrl_pkg::INT_MASK_OFFSET, 32'h1, conv_ctrl_pkg::RESP_OKAY);
    rdc(conv_ctrl_pkg::INT_MASK_OFFSET, 32'h7, 32'h1, conv_ctrl_pkg::RESP_OKAY);
    light <= 1'b0;
    low_side_request <= 1'b0;
    trip_cmd.under <= 1'b1;
    ticks(6);
    check("fault", 1, fault_latched);
    check("drive", 1, low_side_gate_drive);
    check("switching", 0, switching_enable);
    check("irq", 1, irq);
    trip_cmd.under <= 1'b0;
    rdc(conv_ctrl_pkg::STATUS_OFFSET, 32'h7f, 32'h7, conv_ctrl_pkg::RESP_OKAY);
    rdc(conv_ctrl_pkg::INT_STAT_OFFSET, 32'h7, 32'h1, conv_ctrl_pkg::RESP_OKAY);
    ticks(2);
    check("irq", 0, irq);
    pin(4'h2);
    check("fault", 1, fault_latched);
    check("drive", 1, low_side_gate_drive);
    pin(4'h4);
    check("fault", 0, fault_latched);
    cm(2'h1);
    trip_cmd <= 3'h7;
    light <= 1'b1;
    low_side_request <= 1'b1;
    ticks(10);
    check("fault", 0, fault_latched);
    check("skip", 1, skip_active);
    check("drive", 0, low_side_gate_drive);
    trip_cmd <= 3'h0;
    light <= 1'b0;
    pin(4'h1);
    trip_cmd.thermal <= 1'b1;
    ticks(6);
    check("fault", 1, fault_latched);
    trip_cmd.thermal <= 1'b0;
    pin(4'h8);
    check("fault", 0, fault_latched);
    check("drive", 1, low_side_gate_drive);
    check("switching", 0, switching_enable);
    rdc(8'h10, 32'hffffffff, 0, conv_ctrl_pkg::RESP_SLVERR);
    wr(8'h10, 32'h0, conv_ctrl_pkg::RESP_SLVERR);
    wr(conv_ctrl_pkg::STATUS_OFFSET, 32'h7, conv_ctrl_pkg::RESP_OKAY);
    rdc(conv_ctrl_pkg::INT_MASK_OFFSET, 32'h7, 32'h1, conv_ctrl_pkg::RESP_OKAY);
    pin(4'h1);
    trip_cmd.thermal <= 1'b1;
    ticks(6);
    check("fault", 1, fault_latched);
    trip_cmd.thermal <= 1'b0;
    aresetn <= 1'b0;
    ticks(5);
    aresetn <= 1'b1;
    ticks(2);
    check("fault", 0, fault_latched);
    cm(2'h0);
    check("drive", 1, low_side_gate_drive);
    ticks(4);
    cm(2'h3);
    rdc(conv_ctrl_pkg::INT_MASK_OFFSET, 32'h7, 32'h0, conv_ctrl_pkg::RESP_OKAY);
    summarize();
  end
endmodule
